/* bench/serial_line_partner.sv */
// line-side terminal: bit clock source, echo and frame capture
`timescale 1ns/10ps
`default_nettype none
module serial_line_partner
(
   input  wire logic        txd,
   input  wire logic        arm,
   output var  logic        bit_clk,
   output wire logic        rxd,
   output var  logic [15:0] cap,
   output var  int          ncap
);
   // free-running baud source, phase unrelated to clk
   initial
   begin
      bit_clk = 1'b1;
      #3.3;
      forever #32 bit_clk = ~bit_clk;
   end
   // terminal echoes the line straight back
   assign rxd = txd;
   // record line bits at each shift edge, from the start bit on
   always @(negedge bit_clk or posedge arm)
      if (arm)
         ncap <= 0;
      else if (ncap < 16 && (ncap > 0 || txd == 1'b0))
      begin
         cap[ncap] <= txd;
         ncap      <= ncap + 1;
      end
endmodule
`default_nettype wire

/* bench/serial_port_props.sv */
// assertions on the serial port's pins
`timescale 1ns/10ps
`default_nettype none
module serial_port_props
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       clk_en,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic       cd_sel,
   input wire logic [7:0] rdata,
   input wire logic       txd,
   input wire logic       cts_b,
   input wire logic       dtr_b,
   input wire logic       rts_b,
   input wire logic       tx_char_wanted,
   input wire logic       rx_char_waiting,
   input wire logic       tx_drained,
   input wire logic       sync_found_out,
   input wire logic       sync_found_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // host strobes as the port takes them
   wire ctl_wr = clk_en && wr_en && cd_sel;
   sequence data_write;
      clk_en && wr_en && !cd_sel;
   endsequence
   sequence data_read;
      clk_en && rd_en && !cd_sel;
   endsequence
   sequence status_read;
      clk_en && rd_en && cd_sel;
   endsequence
   // reset marks the line and parks every flag
   a_reset_parks: assert property (
      disable iff (1'b0) !rst_b |=> txd && dtr_b && rts_b && tx_drained && !tx_char_wanted
      && !rx_char_waiting && !sync_found_oe && !sync_found_out)
      else $error("outputs not parked by reset");
   a_pins_follow_cmd: assert property (
      $changed({dtr_b, rts_b}) |-> $past(ctl_wr) || $past(ctl_wr, 2) || $past(ctl_wr, 3)
      || !$past(rst_b))
      else $error("modem pin moved without a control write");
   a_rdata_holds: assert property (
      !(clk_en && rd_en) && !ctl_wr && !$past(ctl_wr) |=> $stable(rdata))
      else $error("read data moved without a read");
   a_wanted_permit: assert property (
      cts_b [*8] |=> !tx_char_wanted)
      else $error("char wanted while send permit withheld");
   a_write_clears_wanted: assert property (
      data_write |-> ##[1:2] !tx_char_wanted)
      else $error("char wanted not cleared by a data write");
   a_write_clears_drained: assert property (
      data_write |-> ##[1:2] !tx_drained)
      else $error("drained not cleared by a data write");
   a_read_clears_waiting: assert property (
      data_read |-> ##[1:2] !rx_char_waiting)
      else $error("char waiting not cleared by a data read");
   a_status_clears_sync: assert property (
      sync_found_oe ##0 status_read |-> ##[1:2] !sync_found_out)
      else $error("sync pin not cleared by a status read");
endmodule
bind sync_async_serial_port serial_port_props u_props (.clk, .rst_b, .clk_en, .wr_en, .rd_en,
   .cd_sel, .rdata, .txd, .cts_b, .dtr_b, .rts_b, .tx_char_wanted, .rx_char_waiting,
   .tx_drained, .sync_found_out, .sync_found_oe);
`default_nettype wire

/* bench/sync_async_serial_port_test.sv */
// self-checking bench for the serial port
`timescale 1ns/10ps
`default_nettype none
module sync_async_serial_port_test;
   import serial_port_pkg::*;
   logic        clk, rst_b, wr_en, rd_en, cd_sel, cts_b, arm;
   logic        clk_en = 1'b1, dsr_b = 1'b0, sync_found_in = 1'b0;
   logic [7:0]  wdata, st;
   wire  [7:0]  rdata;
   wire         txd, rxd, bclk, dtr_b, rts_b, tx_char_wanted, rx_char_waiting;
   wire         tx_drained, sync_found_out, sync_found_oe;
   wire  [15:0] cap;
   int          ncap, failures, samples_checked;
   // mode word and character of each ordinary case
   logic [7:0]  rows [3][2] = '{'{8'h4d, 8'ha5}, '{8'h7a, 8'h3c}, '{8'hd3, 8'h13}};

   sync_async_serial_port DUT (.clk, .rst_b, .clk_en, .wr_en, .rd_en, .cd_sel, .wdata,
      .rdata, .tx_bit_clock(bclk), .rx_bit_clock(bclk), .rxd, .txd, .cts_b, .dsr_b,
      .dtr_b, .rts_b, .tx_char_wanted, .rx_char_waiting, .tx_drained, .sync_found_in,
      .sync_found_out, .sync_found_oe);
   serial_line_partner u_line (.txd, .arm, .bit_clk(bclk), .rxd, .cap, .ncap);

   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic cd, input logic [7:0] d);
      wr_en  <= 1'b1;
      cd_sel <= cd;
      wdata  <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic cd, output logic [7:0] v);
      rd_en  <= 1'b1;
      cd_sel <= cd;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
      v = rdata;
   endtask
   task automatic wait_rx();
      for (int i = 0; i < 12000 && rx_char_waiting !== 1'b1; i++)
         @(posedge clk);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // hang guard, well past the expected run
   initial
   begin
      #400000;
      failures++;
      final_report();
   end
   // main sequence
   initial
   begin
      rst_b  = 1'b0;
      wr_en  = 1'b0;
      rd_en  = 1'b0;
      cd_sel = 1'b0;
      wdata  = 8'h00;
      cts_b  = 1'b1;
      arm    = 1'b0;
      repeat (3) @(posedge clk);
      chk("reset pins", 8'hf0, {txd, dtr_b, rts_b, tx_drained, tx_char_wanted,
         rx_char_waiting, sync_found_out, sync_found_oe});
      chk("reset rdata", 8'h00, rdata);
      rst_b <= 1'b1;
      @(posedge clk);
      // permit withheld: nothing may leave
      wr(1'b1, 8'h4d);
      wr(1'b1, 8'h27);
      repeat (40) @(posedge clk);
      chk("modem pins low", 8'h00, {6'h0, dtr_b, rts_b});
      chk("wanted w/o permit", 8'h00, {7'h0, tx_char_wanted});
      wr(1'b0, 8'hff);
      repeat (200) @(posedge clk);
      chk("line w/o permit", 8'h01, {7'h0, txd});
      cts_b <= 1'b0;
      wait_rx();
      rd(1'b0, st);
      chk("char after permit", 8'hff, st);
      wr(1'b1, 8'h40);
      repeat (3) @(posedge clk);
      chk("pins after reinit", 8'h03, {6'h0, dtr_b, rts_b});
      // ordinary frames in loopback, one per row
      for (int r = 0; r < 3; r++)
      begin
         wr(1'b1, rows[r][0]);
         wr(1'b1, 8'h27);
         arm <= 1'b1;
         @(posedge clk);
         arm <= 1'b0;
         wr(1'b0, rows[r][1]);
         wait_rx();
         rd(1'b1, st);
         chk("row status", 8'h82, st & 8'hba);
         rd(1'b0, st);
         chk("row char", rows[r][1] & (8'hff >> (3 - rows[r][0][3:2])), st);
         repeat (20) @(posedge clk);
         if (r == 0)
         begin
            chk("frame data", rows[0][1], cap[8:1]);
            chk("frame ends", 8'h01, {7'h0, cap[9] & ~cap[0]});
         end
         wr(1'b1, 8'h40);
      end
      // unread character is overwritten
      wr(1'b1, 8'h4d);
      wr(1'b1, 8'h27);
      wr(1'b0, 8'h11);
      repeat (40) @(posedge clk);
      wr(1'b0, 8'h22);
      repeat (500) @(posedge clk);
      rd(1'b1, st);
      chk("overrun status", 8'h12, st & 8'h12);
      rd(1'b0, st);
      chk("overrun char", 8'h22, st);
      // break echoes back as a framing fault
      wr(1'b1, 8'h2f);
      repeat (8) @(posedge clk);
      chk("break line", 8'h00, {7'h0, txd});
      repeat (300) @(posedge clk);
      wr(1'b1, 8'h27);
      repeat (20) @(posedge clk);
      rd(1'b1, st);
      chk("framing fault", 8'h20, st & 8'h20);
      wr(1'b1, 8'h37);
      rd(1'b1, st);
      chk("faults cleared", 8'h00, st & 8'h38);
      // character sync: two syncs, fill and hunt
      wr(1'b1, 8'h40);
      wr(1'b1, 8'h0c);
      wr(1'b1, 8'h16);
      wr(1'b1, 8'h16);
      wr(1'b1, 8'ha7);
      repeat (60) @(posedge clk);
      chk("sync idle line", 8'h01, {7'h0, txd});
      wr(1'b0, 8'h16);
      for (int i = 0; i < 4000 && sync_found_out !== 1'b1; i++)
         @(posedge clk);
      chk("sync pin", 8'h03, {6'h0, sync_found_oe, sync_found_out});
      rd(1'b1, st);
      chk("sync status", 8'h44, st & 8'h44);
      wr(1'b0, 8'h55);
      @(posedge clk);
      chk("drained cleared", 8'h00, {7'h0, tx_drained});
      // external sync: pin pulse starts assembly of idle-line chars
      wr(1'b1, 8'h40);
      wr(1'b1, 8'h4c);
      wr(1'b1, 8'h16);
      wr(1'b1, 8'h16);
      wr(1'b1, 8'h27);
      repeat (10) @(posedge clk);
      chk("ext sync pin undriven", 8'h00, {7'h0, sync_found_oe});
      sync_found_in <= 1'b1;
      repeat (10) @(posedge clk);
      rd(1'b1, st);
      chk("ext sync status", 8'h40, st & 8'h40);
      repeat (20) @(posedge clk);
      sync_found_in <= 1'b0;
      wait_rx();
      rd(1'b0, st);
      chk("ext sync char", 8'hff, st);
      final_report();
   end
endmodule
`default_nettype wire

/* common/serial_port_pkg.sv */
// constants and types for the serial port
package serial_port_pkg;
   // mode word fields
   localparam int M_BAUD = 0; // two bits: 0 sync, 1/2/3 = 1x/16x/64x
   localparam int M_LEN  = 2; // two bits: 5..8 data bits
   localparam int M_PEN  = 4;
   localparam int M_EVEN = 5;
   localparam int M_STOP = 6; // async: two bits, 01 = 1 stop, any other = 2 stop
   localparam int M_EXT  = 6; // sync: external sync detect
   localparam int M_ONE  = 7; // sync: single sync character
   localparam logic [1:0] BAUD_SYNC = 2'h0;
   localparam logic [1:0] BAUD_16X  = 2'h2;
   localparam logic [1:0] BAUD_64X  = 2'h3;
   localparam logic [1:0] STOP_ONE  = 2'h1;
   localparam logic [6:0] DIV_1  = 7'h01;
   localparam logic [6:0] DIV_16 = 7'h10;
   localparam logic [6:0] DIV_64 = 7'h40;
   localparam logic [3:0] LEN_MIN = 4'h5;
   // command word fields
   localparam int C_TRANSMIT_ENABLE_BIT = 0;
   localparam int C_DTR  = 1;
   localparam int C_RXE  = 2;
   localparam int C_BRK  = 3;
   localparam int C_ERR  = 4;
   localparam int C_RTS  = 5;
   localparam int C_IR   = 6;
   localparam int C_HUNT = 7;
   // status word fields
   localparam int S_TXW = 0;
   localparam int S_RXW = 1;
   localparam int S_TXE = 2;
   localparam int S_PE  = 3;
   localparam int S_OE  = 4;
   localparam int S_FE  = 5;
   localparam int S_SYN = 6;
   localparam int S_DSR = 7;
   // synchronised input lanes
   localparam int NSYNC = 6;
   localparam int I_TXC = 0;
   localparam int I_RXC = 1;
   localparam int I_RXD = 2;
   localparam int I_CTS = 3;
   localparam int I_DSR = 4;
   localparam int I_SYN = 5;
   typedef enum logic [3:0] {
      PH_MODE  = 4'b0001,
      PH_SYNC1 = 4'b0010,
      PH_SYNC2 = 4'b0100,
      PH_CMD   = 4'b1000
   } wr_phase_t;
   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_BITS  = 4'b0100,
      RX_HUNT  = 4'b1000
   } rx_state_t;
endpackage

/* rtl/sync_async_serial_port.sv */
// serial port with async and character-sync modes
`timescale 1ns/10ps
`default_nettype none
module sync_async_serial_port
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   input  wire logic       cd_sel,
   input  wire logic [7:0] wdata,
   output var  logic [7:0] rdata,
   input  wire logic       tx_bit_clock,
   input  wire logic       rx_bit_clock,
   input  wire logic       rxd,
   output var  logic       txd,
   input  wire logic       cts_b,
   input  wire logic       dsr_b,
   output var  logic       dtr_b,
   output var  logic       rts_b,
   output var  logic       tx_char_wanted,
   output var  logic       rx_char_waiting,
   output var  logic       tx_drained,
   input  wire logic       sync_found_in,
   output var  logic       sync_found_out,
   output var  logic       sync_found_oe
);
   import serial_port_pkg::*;

   // host strobes
   wire ctl_wr = wr_en & cd_sel;
   wire dat_wr = wr_en & ~cd_sel;
   wire sts_rd = rd_en & cd_sel;
   wire dat_rd = rd_en & ~cd_sel;

   wr_phase_t  ph_q;
   logic [7:0] mode_q, sync1_q, sync2_q, cmd_q;
   wire reinit = ctl_wr & (ph_q == PH_CMD) & wdata[C_IR];
   wire clr    = ~rst_b | (clk_en & reinit);

   // control write sequencing
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ph_q    <= PH_MODE;
         mode_q  <= 8'h00;
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
         cmd_q   <= 8'h00;
      end
      else if (clk_en && ctl_wr)
      begin
         unique case (ph_q)
            PH_MODE:
            begin
               mode_q <= wdata;
               ph_q   <= (wdata[M_BAUD+:2] == BAUD_SYNC) ? PH_SYNC1 : PH_CMD;
            end
            PH_SYNC1:
            begin
               sync1_q <= wdata;
               ph_q    <= mode_q[M_ONE] ? PH_CMD : PH_SYNC2;
            end
            PH_SYNC2:
            begin
               sync2_q <= wdata;
               ph_q    <= PH_CMD;
            end
            PH_CMD:
            begin
               cmd_q <= wdata[C_IR] ? 8'h00 : wdata;
               ph_q  <= wdata[C_IR] ? PH_MODE : PH_CMD;
            end
         endcase
      end
   end

   // three-stage sampling of outside inputs
   logic [NSYNC-1:0] s1_q, s2_q, s3_q, f_q, fp_q;
   wire  [NSYNC-1:0] pins = {sync_found_in, dsr_b, cts_b, rxd, rx_bit_clock, tx_bit_clock};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_in
         always_ff @(posedge clk)
         begin
            if (!rst_b)
            begin
               s1_q[gi] <= 1'b1;
               s2_q[gi] <= 1'b1;
               s3_q[gi] <= 1'b1;
               f_q[gi]  <= 1'b1;
               fp_q[gi] <= 1'b1;
            end
            else if (clk_en)
            begin
               s1_q[gi] <= pins[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               f_q[gi]  <= (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : f_q[gi];
               fp_q[gi] <= f_q[gi];
            end
         end
      end
   endgenerate

   wire tx_fall = fp_q[I_TXC] & ~f_q[I_TXC];
   wire rx_rise = ~fp_q[I_RXC] & f_q[I_RXC];
   wire rxd_f   = f_q[I_RXD];

   // mode decode
   wire       is_sync = mode_q[M_BAUD+:2] == BAUD_SYNC;
   wire [3:0] nbits   = LEN_MIN + {2'b00, mode_q[M_LEN+:2]};
   wire [7:0] mask    = 8'hff >> (2'h3 - mode_q[M_LEN+:2]);
   wire       pen     = mode_q[M_PEN];
   wire       odd     = ~mode_q[M_EVEN];
   wire [6:0] div     = (mode_q[M_BAUD+:2] == BAUD_64X) ? DIV_64 :
                        (mode_q[M_BAUD+:2] == BAUD_16X) ? DIV_16 : DIV_1;
   wire [6:0] half    = div >> 1;
   wire [3:0] nstop   = (mode_q[M_STOP+:2] == STOP_ONE) ? 4'h1 : 4'h2;

   // serial frame: count in top nibble, bits lsb first
   function automatic logic [15:0] frame_of(input logic [7:0] d);
      logic [11:0] f;
      logic [3:0]  k;
      f = 12'hfff;
      k = 4'h0;
      if (!is_sync)
      begin
         f[0] = 1'b0;
         k = 4'h1;
      end
      for (int i = 0; i < 8; i++)
      begin
         if (4'(i) < nbits)
         begin
            f[k] = d[i];
            k = k + 4'h1;
         end
      end
      if (pen)
      begin
         f[k] = (^(d & mask)) ^ odd;
         k = k + 4'h1;
      end
      if (!is_sync)
         k = k + nstop;
      return {k, f};
   endfunction

   // transmitter
   logic [7:0]  thr_q;
   logic        thr_full_q, started_q, fill2_q, line_q, drained_q;
   logic [11:0] tsr_q;
   logic [3:0]  tbits_q;
   logic [6:0]  tdiv_q;
   wire        can_send = cmd_q[C_TRANSMIT_ENABLE_BIT] & ~f_q[I_CTS];
   wire        tdiv_end = (tdiv_q + 7'h01) >= div;
   wire        tx_tick  = tx_fall & (is_sync | tdiv_end);
   wire        load_chr = (tbits_q == 4'h0) & thr_full_q & can_send;
   wire        load_fil = (tbits_q == 4'h0) & ~load_chr & is_sync & started_q;
   wire [7:0]  fil_chr  = (fill2_q & ~mode_q[M_ONE]) ? sync2_q : sync1_q;
   wire [15:0] fr       = frame_of(load_chr ? thr_q : fil_chr);

   always_ff @(posedge clk)
   begin
      if (clr)
      begin
         thr_q <= 8'h00;
         thr_full_q <= 1'b0;
         started_q <= 1'b0;
         fill2_q <= 1'b0;
         line_q <= 1'b1;
         drained_q <= 1'b1;
         tsr_q <= 12'hfff;
         tbits_q <= 4'h0;
         tdiv_q <= 7'h00;
      end
      else if (clk_en)
      begin
         if (tx_fall)
            tdiv_q <= tdiv_end ? 7'h00 : tdiv_q + 7'h01;
         if (tx_tick && tbits_q != 4'h0)
         begin
            line_q  <= tsr_q[0];
            tsr_q   <= {1'b1, tsr_q[11:1]};
            tbits_q <= tbits_q - 4'h1;
         end
         else if (tx_tick && (load_chr || load_fil))
         begin
            line_q    <= fr[0];
            tsr_q     <= {1'b1, fr[11:1]};
            tbits_q   <= fr[15:12] - 4'h1;
            started_q <= 1'b1;
            fill2_q   <= load_fil ? ~fill2_q : 1'b0;
         end
         else if (tx_tick)
            line_q <= 1'b1;
         if (dat_wr)
         begin
            thr_q <= wdata;
            thr_full_q <= 1'b1;
         end
         else if (tx_tick && load_chr)
            thr_full_q <= 1'b0;
         if (dat_wr)
            drained_q <= 1'b0;
         else if (tx_tick && tbits_q == 4'h0 && !load_chr)
            drained_q <= 1'b1;
      end
   end

   // receiver
   rx_state_t  rs_q;
   logic [7:0] rdat_q, rbr_q, hsr_q, rdat_n;
   logic [3:0] ridx_q;
   logic [6:0] rcnt_q;
   logic       rlast_q, rpar_q, hunt2_q;
   logic       rxw_q, pe_q, oe_q, fe_q, syn_q;
   wire        rx_on    = cmd_q[C_RXE] & (ph_q == PH_CMD);
   wire        rcnt_end = (rcnt_q + 7'h01) >= div;
   wire        sample   = rx_rise & (is_sync | rcnt_end);
   wire [3:0]  rlast    = nbits + {3'h0, pen} - {3'h0, is_sync};
   wire        rpar_n   = (ridx_q == nbits) ? rxd_f : rpar_q;
   wire        done     = (rs_q == RX_BITS) & sample & (ridx_q == rlast);
   wire        deliver  = done & ~hunt2_q;
   wire [7:0]  hwin     = {rxd_f, hsr_q[7:1]} >> (4'h8 - nbits);
   wire        hmatch1  = hwin == (sync1_q & mask);
   wire        hmatch2  = (rdat_n & mask) == (sync2_q & mask);
   wire        found    = (rs_q == RX_HUNT) & rx_rise & ~mode_q[M_EXT] & hmatch1
                          & mode_q[M_ONE] | done & hunt2_q & hmatch2;
   wire        par_bad  = pen & (rpar_n != ((^(rdat_n & mask)) ^ odd));

   // insert the bit under sample into the char
   always_comb
   begin
      rdat_n = rdat_q;
      if (ridx_q < nbits)
         rdat_n[ridx_q[2:0]] = rxd_f;
   end

   always_ff @(posedge clk)
   begin
      if (clr)
      begin
         rs_q <= RX_IDLE;
         rdat_q <= 8'h00;
         hsr_q <= 8'h00;
         ridx_q <= 4'h0;
         rcnt_q <= 7'h00;
         rlast_q <= 1'b1;
         rpar_q <= 1'b0;
         hunt2_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (rx_rise)
            rlast_q <= rxd_f;
         if (!rx_on)
            rs_q <= RX_IDLE;
         else if (is_sync && ctl_wr && wdata[C_HUNT] && !wdata[C_IR])
            rs_q <= RX_HUNT;
         else
         begin
            unique case (rs_q)
               RX_IDLE:
                  if (is_sync)
                     rs_q <= RX_HUNT;
                  else if (rx_rise && rlast_q && !rxd_f)
                  begin
                     rs_q   <= (half == 7'h00) ? RX_BITS : RX_START;
                     rcnt_q <= 7'h00;
                     ridx_q <= 4'h0;
                  end
               RX_START:
                  if (rx_rise && rcnt_q + 7'h01 >= half)
                  begin
                     rs_q   <= rxd_f ? RX_IDLE : RX_BITS;
                     rcnt_q <= 7'h00;
                  end
                  else if (rx_rise)
                     rcnt_q <= rcnt_q + 7'h01;
               RX_BITS:
                  if (sample)
                  begin
                     rcnt_q <= 7'h00;
                     rdat_q <= rdat_n;
                     rpar_q <= rpar_n;
                     ridx_q <= done ? 4'h0 : ridx_q + 4'h1;
                     if (done && (!is_sync || (hunt2_q && !hmatch2)))
                        rs_q <= is_sync ? RX_HUNT : RX_IDLE;
                     if (done)
                        hunt2_q <= 1'b0;
                  end
                  else if (rx_rise)
                     rcnt_q <= rcnt_q + 7'h01;
               RX_HUNT:
               begin
                  ridx_q <= 4'h0;
                  if (rx_rise)
                     hsr_q <= {rxd_f, hsr_q[7:1]};
                  if (mode_q[M_EXT] && f_q[I_SYN])
                     rs_q <= RX_BITS;
                  else if (rx_rise && hmatch1)
                  begin
                     rs_q    <= RX_BITS;
                     hunt2_q <= ~mode_q[M_ONE];
                  end
               end
            endcase
         end
      end
   end

   // receive buffer and sticky fault flags
   wire err_clr = ctl_wr & (ph_q == PH_CMD) & wdata[C_ERR];
   always_ff @(posedge clk)
   begin
      if (clr)
      begin
         rbr_q <= 8'h00;
         rxw_q <= 1'b0;
         pe_q  <= 1'b0;
         oe_q  <= 1'b0;
         fe_q  <= 1'b0;
         syn_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (deliver)
            rbr_q <= rdat_n & mask;
         rxw_q <= deliver | (rxw_q & ~dat_rd);
         pe_q  <= (deliver & par_bad) | (pe_q & ~err_clr);
         oe_q  <= (deliver & rxw_q & ~dat_rd) | (oe_q & ~err_clr);
         fe_q  <= (deliver & ~is_sync & ~rxd_f) | (fe_q & ~err_clr);
         syn_q <= found | (syn_q & ~sts_rd);
      end
   end

   // status word and registered pins
   logic [7:0] status;
   always_comb
   begin
      status        = 8'h00;
      status[S_TXW] = tx_char_wanted;
      status[S_RXW] = rxw_q;
      status[S_TXE] = drained_q;
      status[S_PE]  = pe_q;
      status[S_OE]  = oe_q;
      status[S_FE]  = fe_q;
      status[S_SYN] = mode_q[M_EXT] ? f_q[I_SYN] : syn_q;
      status[S_DSR] = ~f_q[I_DSR];
   end

   always_ff @(posedge clk)
   begin
      if (clr)
      begin
         rdata <= 8'h00;
         txd <= 1'b1;
         dtr_b <= 1'b1;
         rts_b <= 1'b1;
         tx_char_wanted <= 1'b0;
         rx_char_waiting <= 1'b0;
         tx_drained <= 1'b1;
         sync_found_out <= 1'b0;
         sync_found_oe <= 1'b0;
      end
      else if (clk_en)
      begin
         if (rd_en)
            rdata <= cd_sel ? status : rbr_q;
         txd <= line_q & ~cmd_q[C_BRK];
         dtr_b <= ~cmd_q[C_DTR];
         rts_b <= ~cmd_q[C_RTS];
         tx_char_wanted <= ~thr_full_q & ~dat_wr & can_send;
         rx_char_waiting <= rxw_q;
         tx_drained <= drained_q;
         sync_found_out <= syn_q;
         sync_found_oe <= is_sync & ~mode_q[M_EXT] & (ph_q != PH_MODE);
      end
   end
endmodule
`default_nettype wire
